//--- design/txcrc_pkg.sv
`default_nettype none
package txcrc_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] TXCRC_CFG_IDX = 8'h19;
    localparam logic [7:0] TXCRC_STAT_IDX = 8'h1a;
    localparam logic [31:0] TXCRC_CFG_RESET = 32'h0000_0000;
    localparam logic [31:0] TXCRC_CFG_WMASK = 32'hffff_007f;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int TXCRC_APPEND_BIT = 0;
    localparam int TXCRC_COMPL_BIT = 1;
    localparam int TXCRC_WIDTH_BIT = 2;
    localparam int TXCRC_SEL_LSB = 3;
    localparam int TXCRC_SKIP_BIT = 6;
    localparam int TXCRC_SEED_LSB = 16;

    // ------------------------------------------------------------
    // Seed table and polynomials
    // ------------------------------------------------------------
    localparam logic [2:0] TXCRC_SEL_CUSTOM = 3'h7;
    localparam logic [15:0] TXCRC_SEED0 = 16'h0000;
    localparam logic [15:0] TXCRC_SEED1 = 16'h6363;
    localparam logic [15:0] TXCRC_SEED2 = 16'ha671;
    localparam logic [15:0] TXCRC_SEED3 = 16'hffff;
    localparam logic [15:0] TXCRC_SEED4 = 16'h0012;
    localparam logic [15:0] TXCRC_SEED5 = 16'he012;
    localparam logic [15:0] TXCRC_POLY16_REFL = 16'h8408;
    localparam logic [4:0] TXCRC_POLY5_REFL = 5'h12;

    typedef enum logic [1:0] {
        TXCRC_IDLE,
        TXCRC_DATA,
        TXCRC_TAIL
    } txcrc_state_t;

endpackage
`default_nettype wire

//--- design/txcrc_gen.sv
`timescale 1ns/100ps
`default_nettype none
module txcrc_gen (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic frame_start,
    input wire logic in_valid,
    input wire logic [7:0] in_data,
    input wire logic in_last,
    output logic in_ready,
    output logic out_valid,
    output logic [7:0] out_data,
    output logic out_last,
    input wire logic out_ready
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [31:0] cfg;
        logic [31:0] rdata;
        txcrc_pkg::txcrc_state_t st;
        logic [15:0] crc;
        logic first;
        logic [15:0] tail;
        logic tail_two;
        logic ov;
        logic [7:0] od;
        logic ol;
        logic [7:0] frames;
    } txcrc_regs_t;

    txcrc_regs_t r_ff;
    txcrc_regs_t nxt_r;

    logic [2:0] sel;
    logic [15:0] seed;
    logic [15:0] crc_upd;
    logic [15:0] fin;
    logic out_free;
    logic take;
    logic w16;

    assign sel = r_ff.cfg[txcrc_pkg::TXCRC_SEL_LSB +: 3];
    assign w16 = ~r_ff.cfg[txcrc_pkg::TXCRC_WIDTH_BIT];
    assign out_free = ~r_ff.ov | out_ready;
    assign in_ready = (r_ff.st == txcrc_pkg::TXCRC_DATA) && out_free;
    assign take = in_valid && in_ready;
    assign out_valid = r_ff.ov;
    assign out_data = r_ff.od;
    assign out_last = r_ff.ol;
    assign reg_rdata = r_ff.rdata;

    // ------------------------------------------------------------
    // Seed selection
    // ------------------------------------------------------------
    always_comb
    begin
        if (sel == 3'h0)
            seed = txcrc_pkg::TXCRC_SEED0;
        else if (sel == 3'h1)
            seed = txcrc_pkg::TXCRC_SEED1;
        else if (sel == 3'h2)
            seed = txcrc_pkg::TXCRC_SEED2;
        else if (sel == 3'h3)
            seed = txcrc_pkg::TXCRC_SEED3;
        else if (sel == 3'h4)
            seed = txcrc_pkg::TXCRC_SEED4;
        else if (sel == 3'h5)
            seed = txcrc_pkg::TXCRC_SEED5;
        else if (sel == txcrc_pkg::TXCRC_SEL_CUSTOM)
            seed = r_ff.cfg[txcrc_pkg::TXCRC_SEED_LSB +: 16];
        else
            seed = txcrc_pkg::TXCRC_SEED0;
        if (!w16)
            seed = {8'h00, seed[7:0]};
    end

    // ------------------------------------------------------------
    // Byte update, LSB first
    // ------------------------------------------------------------
    always_comb
    begin
        logic [15:0] c;
        logic fb;
        c = r_ff.crc;
        fb = 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            if (w16)
            begin
                fb = c[0] ^ in_data[i];
                c = {1'b0, c[15:1]};
                if (fb)
                    c = c ^ txcrc_pkg::TXCRC_POLY16_REFL;
            end
            else
            begin
                fb = c[0] ^ in_data[i];
                c = {12'h000, c[4:1]};
                if (fb)
                    c = c ^ {11'h000, txcrc_pkg::TXCRC_POLY5_REFL};
            end
        end
        crc_upd = c;
    end

    // Final value: complement and width trim
    always_comb
    begin
        fin = r_ff.cfg[txcrc_pkg::TXCRC_COMPL_BIT] ? ~r_ff.crc : r_ff.crc;
        if (!w16)
            fin = {11'h000, fin[4:0]};
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_r = r_ff;
        nxt_r.rdata = 32'h0000_0000;
        if (reg_rd)
        begin
            if (reg_addr == txcrc_pkg::TXCRC_CFG_IDX)
                nxt_r.rdata = r_ff.cfg;
            else if (reg_addr == txcrc_pkg::TXCRC_STAT_IDX)
                nxt_r.rdata = {8'h00, r_ff.frames, r_ff.crc};
            else
                nxt_r.rdata = 32'h0000_0000;
        end
        if (reg_wr && reg_addr == txcrc_pkg::TXCRC_CFG_IDX)
            nxt_r.cfg = reg_wdata & txcrc_pkg::TXCRC_CFG_WMASK;
        if (out_ready)
            nxt_r.ov = 1'b0;
        case (r_ff.st)
            txcrc_pkg::TXCRC_IDLE:
            begin
                if (frame_start)
                begin
                    nxt_r.crc = seed;
                    nxt_r.first = 1'b1;
                    nxt_r.st = txcrc_pkg::TXCRC_DATA;
                end
            end
            txcrc_pkg::TXCRC_DATA:
            begin
                if (take)
                begin
                    nxt_r.ov = 1'b1;
                    nxt_r.od = in_data;
                    nxt_r.first = 1'b0;
                    if (!(r_ff.first && r_ff.cfg[txcrc_pkg::TXCRC_SKIP_BIT]))
                        nxt_r.crc = crc_upd;
                    nxt_r.ol = in_last
                        && !r_ff.cfg[txcrc_pkg::TXCRC_APPEND_BIT];
                    if (in_last)
                    begin
                        if (r_ff.cfg[txcrc_pkg::TXCRC_APPEND_BIT])
                            nxt_r.st = txcrc_pkg::TXCRC_TAIL;
                        else
                        begin
                            nxt_r.st = txcrc_pkg::TXCRC_IDLE;
                            nxt_r.frames = r_ff.frames + 8'h01;
                        end
                        nxt_r.tail_two = 1'b1;
                    end
                end
            end
            txcrc_pkg::TXCRC_TAIL:
            begin
                if (out_free)
                begin
                    nxt_r.ov = 1'b1;
                    if (r_ff.tail_two)
                    begin
                        nxt_r.od = fin[7:0];
                        nxt_r.tail = fin;
                        nxt_r.tail_two = 1'b0;
                        nxt_r.ol = !w16;
                        if (!w16)
                        begin
                            nxt_r.st = txcrc_pkg::TXCRC_IDLE;
                            nxt_r.frames = r_ff.frames + 8'h01;
                        end
                    end
                    else
                    begin
                        nxt_r.od = r_ff.tail[15:8];
                        nxt_r.ol = 1'b1;
                        nxt_r.st = txcrc_pkg::TXCRC_IDLE;
                        nxt_r.frames = r_ff.frames + 8'h01;
                    end
                end
            end
            default:
                nxt_r.st = txcrc_pkg::TXCRC_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            r_ff <= '0;
            r_ff.cfg <= txcrc_pkg::TXCRC_CFG_RESET;
            r_ff.st <= txcrc_pkg::TXCRC_IDLE;
        end
        else
            r_ff <= nxt_r;
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_last_taken;
        take && in_last;
    endsequence

    property p_no_append;
        @(posedge core_clk) disable iff (!rstn)
        (s_last_taken and !r_ff.cfg[0]) |=> out_valid && out_last;
    endproperty
    a_no_append: assert property (p_no_append)
        else $error("frame without checksum did not end on data byte");

    property p_len16;
        @(posedge core_clk) disable iff (!rstn)
        (s_last_taken and (r_ff.cfg[0] && !r_ff.cfg[2] && out_ready))
        ##1 out_ready ##1 out_ready |=> out_last;
    endproperty
    a_len16: assert property (p_len16)
        else $error("16-bit checksum not two bytes");

    property p_len5;
        @(posedge core_clk) disable iff (!rstn)
        (s_last_taken and (r_ff.cfg[0] && r_ff.cfg[2] && out_ready))
        ##1 out_ready |=> out_last && out_data[7:5] == 3'h0;
    endproperty
    a_len5: assert property (p_len5)
        else $error("5-bit checksum not one byte");

    property p_compl;
        @(posedge core_clk) disable iff (!rstn)
        r_ff.st == txcrc_pkg::TXCRC_TAIL && r_ff.tail_two && out_free
        && w16 && r_ff.cfg[1] |=> out_data == ~$past(r_ff.crc[7:0]);
    endproperty
    a_compl: assert property (p_compl)
        else $error("checksum not complemented");

    property p_seed;
        @(posedge core_clk) disable iff (!rstn)
        r_ff.st == txcrc_pkg::TXCRC_IDLE && frame_start && w16
        && sel == 3'h1 |=> r_ff.crc == 16'h6363;
    endproperty
    a_seed: assert property (p_seed)
        else $error("table seed not loaded");

    property p_custom;
        @(posedge core_clk) disable iff (!rstn)
        r_ff.st == txcrc_pkg::TXCRC_IDLE && frame_start && w16
        && sel == 3'h7 |=> r_ff.crc == $past(r_ff.cfg[31:16]);
    endproperty
    a_custom: assert property (p_custom)
        else $error("custom seed not loaded");

    property p_rsvd;
        @(posedge core_clk) disable iff (!rstn)
        reg_rd && reg_addr == txcrc_pkg::TXCRC_CFG_IDX
        |=> reg_rdata[15:7] == 9'h000;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved bits read nonzero");

    property p_seed5;
        @(posedge core_clk) disable iff (!rstn)
        r_ff.st == txcrc_pkg::TXCRC_IDLE && frame_start && !w16
        |=> r_ff.crc[15:8] == 8'h00;
    endproperty
    a_seed5: assert property (p_seed5)
        else $error("5-bit seed upper byte used");

    property p_skip;
        @(posedge core_clk) disable iff (!rstn)
        take && r_ff.first && r_ff.cfg[6] |=> $stable(r_ff.crc);
    endproperty
    a_skip: assert property (p_skip)
        else $error("first byte entered checksum");

endmodule
`default_nettype wire

//--- verification/txcrc_enc_model.sv
`timescale 1ns/100ps
`default_nettype none
module txcrc_enc_model (
    input wire logic core_clk,
    input wire logic in_ready,
    output logic frame_start,
    output logic in_valid,
    output logic [7:0] in_data,
    output logic in_last
);
    // ----------------------------------------
    // Frame source, called right after an edge
    // ----------------------------------------
    initial
    begin
        frame_start = 1'b0;
        in_valid = 1'b0;
        in_data = 8'h5a;
        in_last = 1'b0;
    end

    task automatic send(input int n, input bit slow);
        frame_start <= 1'b1;
        @(posedge core_clk);
        frame_start <= 1'b0;
        for (int i = 0; i < n; i++)
        begin
            // Idle gaps: data toggles so stale bytes never look valid
            if (slow)
                repeat ($urandom_range(2))
                begin
                    in_valid <= 1'b0;
                    in_data <= ~in_data;
                    @(posedge core_clk);
                end
            in_valid <= 1'b1;
            in_data <= 8'($urandom);
            in_last <= (i == n - 1);
            forever
            begin
                @(negedge core_clk);
                if (in_ready === 1'b1)
                    break;
            end
            @(posedge core_clk);
        end
        in_valid <= 1'b0;
        in_last <= 1'b0;
        in_data <= ~in_data;
    endtask
endmodule
`default_nettype wire

//--- verification/tx_crc_generator_config_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tx_crc_generator_config_tb_top;
    logic core_clk, rstn, reg_wr, reg_rd, out_ready, rd_pend, first;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, cfg, cur_cfg;
    logic frame_start, in_valid, in_last, in_ready, out_valid, out_last;
    logic [7:0] in_data, out_data;
    logic [15:0] crc, x;
    logic [31:0] rq[$];
    logic [8:0] oq[$];
    int err_count = 0;
    int n_compared = 0;

    txcrc_gen dut (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .frame_start(frame_start),
        .in_valid(in_valid), .in_data(in_data), .in_last(in_last),
        .in_ready(in_ready), .out_valid(out_valid), .out_data(out_data),
        .out_last(out_last), .out_ready(out_ready));
    txcrc_enc_model enc (.core_clk(core_clk), .in_ready(in_ready),
        .frame_start(frame_start), .in_valid(in_valid), .in_data(in_data),
        .in_last(in_last));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("mismatches %0d compared %0d", err_count, n_compared);
        if (err_count == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        rq.push_back(e);
        @(posedge core_clk);
        reg_rd <= 1'b0;
    endtask

    function automatic logic [15:0] seed_of(input logic [31:0] c);
        case (c[5:3])
            3'h1: seed_of = 16'h6363;
            3'h2: seed_of = 16'ha671;
            3'h3: seed_of = 16'hffff;
            3'h4: seed_of = 16'h0012;
            3'h5: seed_of = 16'he012;
            3'h7: seed_of = c[31:16];
            default: seed_of = 16'h0000;
        endcase
    endfunction

    function automatic logic [15:0] upd(input logic [15:0] c,
        input logic [7:0] d, input logic w5);
        logic fb;
        for (int i = 0; i < 8; i++)
        begin
            fb = c[0] ^ d[i];
            c = w5 ? {12'h000, c[4:1]} : {1'b0, c[15:1]};
            if (fb)
                c = c ^ (w5 ? 16'h0012 : 16'h8408);
        end
        return c;
    endfunction

    // ----------------------------------------
    // Expectations and monitors
    // ----------------------------------------
    always @(posedge core_clk)
    begin
        if (frame_start === 1'b1)
        begin
            crc = cur_cfg[2] ? (seed_of(cur_cfg) & 16'h001f) : seed_of(cur_cfg);
            first = 1'b1;
        end
        if (in_valid === 1'b1 && in_ready === 1'b1)
        begin
            oq.push_back({in_last & ~cur_cfg[0], in_data});
            if (!(first && cur_cfg[6]))
                crc = upd(crc, in_data, cur_cfg[2]);
            first = 1'b0;
            x = cur_cfg[1] ? ~crc : crc;
            if (in_last && cur_cfg[0] && cur_cfg[2])
                oq.push_back({1'b1, 3'h0, x[4:0]});
            else if (in_last && cur_cfg[0])
            begin
                oq.push_back({1'b0, x[7:0]});
                oq.push_back({1'b1, x[15:8]});
            end
        end
        if (out_valid === 1'b1 && out_ready === 1'b1)
            check({23'h0, out_last, out_data}, {23'h0, oq.pop_front()});
        if (rd_pend)
            check(reg_rdata, rq.pop_front());
        rd_pend <= reg_rd;
        out_ready <= ($urandom_range(3) != 0);
    end

    // ----------------------------------------
    // Clock, watchdog, main sequence
    // ----------------------------------------
    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    initial
    begin
        #200us;
        err_count++;
        final_report();
    end

    initial
    begin
        {rstn, reg_wr, reg_rd, rd_pend, first} = 5'h0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        out_ready = 1'b1;
        cur_cfg = 32'h0;
        crc = 16'h0;
        void'($urandom(72329));
        repeat (4) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        rd(8'h19, 32'h0);
        wr(8'h19, 32'hffffffff);
        rd(8'h19, 32'hffff007f);
        @(posedge core_clk);
        rd(8'h33, 32'h0);
        for (int k = 0; k < 18; k++)
        begin
            cfg = {16'($urandom), 9'h0, 1'($urandom), 3'(k), k[3],
                1'($urandom), 1'(k != 5)};
            wr(8'h19, cfg);
            rd(8'h19, cfg);
            cur_cfg = cfg;
            enc.send(1 + $urandom_range(5), k[0]);
            // Let the monitor note the last byte before draining
            @(posedge core_clk);
            for (int t = 0; t < 200 && oq.size() != 0; t++)
                @(posedge core_clk);
            check(32'(oq.size()), 32'h0);
        end
        // Status: frames completed and last checksum register
        rd(8'h1a, {8'h00, 8'h12, crc});
        repeat (2) @(posedge core_clk);
        final_report();
    end
endmodule
`default_nettype wire
